// >>> verilog/ssfb_status_flag_bank.sv
// Status flag bank: second LIN fault reporting with recovery and transmit
// re-enable, latched wake sources, input levels with straps, high-side flags.
// Assumes a serial port decoder delivering one-cycle register accesses, and
// detection circuits delivering one-cycle events on the same clock.
`timescale 1ns/100ps

// Functional notes
// - Second LIN fault code at bits 2:1: none, thermal, transmit stuck, bus stuck.
// - Bus and transmit stuck faults flagged only after 20 ms continuous dominant.
// - Transmit stuck recovers on transmit input high, wake-capable or off.
// - Bus stuck recovers on bus recessive, wake-capable or off.
// - Supply undervoltage recovers once supply rises above its threshold.
// - After any fault, transmit re-enabled only after input high for enable time.
// - Wake flags: LIN2 bit7, LIN1 bit6, CAN bit5, timer bit4, inputs bits 2..0.
// - Wake out of fail-safe also sets the responsible source flag.
// - Reserved bit positions always read as zero.
// - Level register bit 7 shows test pin mode: 0 user, 1 development.
// - Bit 6 shows interrupt pull-up strap: 0 absent, 1 present.
// - Levels 0 low, 1 high: inputs bits 2..0, general pins bits 5,4.
// - General pin level bits update in normal and stop modes when pin configured.
// - Cyclic sensed wake inputs show the sampled level, refreshed per sample.
// - General-purpose pins have no cyclic sensing.
// - General pin level shown even when used as a switch.
// - Overload flag per high-side switch, switch four bit 3 to one bit 0.
// - Open-load flag per high-side switch, switch four bit 3 to one bit 0.
// - Power-on reset clears all; soft reset clears all but the level register; restart clears nothing.
module ssfb_status_flag_bank #(
  parameter int DOM_TIMEOUT_CYCLES = int'(ssfb_pkg::DOMINANT_TIMEOUT_CYCLES),
  parameter int TX_EN_CYCLES = int'(ssfb_pkg::TX_ENABLE_CYCLES),
  parameter int NUM_WAKE_INPUTS = 3,
  parameter int NUM_HS = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic restart,
  // Register access from the serial port decoder
  input wire logic acc_valid,
  input wire logic [6:0] acc_addr,
  input wire logic acc_clear,
  output logic rd_valid,
  output logic [7:0] rd_data,
  // Second LIN transceiver
  input wire logic lin2_txd_pin,
  input wire logic lin2_bus_dominant_pin,
  input wire logic lin2_wake_or_off,
  input wire logic lin2_thermal_event,
  input wire logic lin2_thermal_active,
  input wire logic supply_uv_event,
  input wire logic supply_above_uv,
  output logic lin2_tx_enable,
  // Wake sources
  input wire logic second_lin_wake,
  input wire logic first_lin_wake,
  input wire logic can_bus_wake,
  input wire logic timer_wake,
  input wire logic [2:0] wake_input_event,
  input wire logic [1:0] gp_pin_wake,
  input wire logic failsafe_exit,
  input wire logic [6:0] failsafe_wake_source,
  // Levels and straps
  input wire logic test_select_pin,
  input wire logic interrupt_pullup_pin,
  input wire logic [2:0] wake_input_pin,
  input wire logic [2:0] wake_input_cyclic,
  input wire logic [2:0] wake_input_sample,
  input wire logic [1:0] gp_pin,
  input wire logic [1:0] gp_pin_cfg,
  input wire logic [1:0] gp_pin_cfg_b,
  input wire logic normal_or_stop_mode,
  // High-side switch detectors
  input wire logic [3:0] hs_overload_event,
  input wire logic [3:0] hs_open_load_event
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Register hit for a clear command
  function automatic logic clear_hit(input logic v, input logic c, input logic [6:0] a,
                                     input logic [6:0] off);
    clear_hit = v && c && (a == off);
  endfunction

  logic flag_clear_all;
  assign flag_clear_all = soft_reset;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  assign pin_raw = {lin2_txd_pin, lin2_bus_dominant_pin, test_select_pin,
                    interrupt_pullup_pin, wake_input_pin, gp_pin, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      // Two flops per pin; only the second is read. No reset: the pins keep
      // flowing through during reset, so the straps are settled at release
      always_ff @(posedge clock)
      begin
        sync_a[gi] <= pin_raw[gi];
        sync_b[gi] <= sync_a[gi];
      end
    end
  endgenerate

  logic txd_high;
  logic bus_dom;
  logic test_lvl;
  logic pullup_lvl;
  logic [2:0] wk_lvl;
  logic [1:0] gp_lvl;
  assign txd_high = sync_b[9];
  assign bus_dom = sync_b[8];
  assign test_lvl = sync_b[7];
  assign pullup_lvl = sync_b[6];
  assign wk_lvl = sync_b[5:3];
  assign gp_lvl = sync_b[2:1];

  // ---------------------------------------------------------------
  // Dominant timeouts
  // ---------------------------------------------------------------
  logic [31:0] txd_low_cnt;
  logic [31:0] bus_dom_cnt;
  logic tx_stuck_event;
  logic bus_stuck_event;

  // Events fire once, on the cycle the count passes 20 ms
  assign tx_stuck_event = (txd_low_cnt == 32'(DOM_TIMEOUT_CYCLES));
  assign bus_stuck_event = (bus_dom_cnt == 32'(DOM_TIMEOUT_CYCLES));

  // Saturating counters; held at zero while the condition is absent
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      txd_low_cnt <= 32'h0;
      bus_dom_cnt <= 32'h0;
    end
    else
    begin
      if (txd_high || !lin2_tx_enable)
        txd_low_cnt <= 32'h0;
      else if (txd_low_cnt <= 32'(DOM_TIMEOUT_CYCLES))
        txd_low_cnt <= txd_low_cnt + 32'h1;
      if (!bus_dom)
        bus_dom_cnt <= 32'h0;
      else if (bus_dom_cnt <= 32'(DOM_TIMEOUT_CYCLES))
        bus_dom_cnt <= bus_dom_cnt + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter recovery state machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {SSFB_TX_ON, SSFB_TX_THERMAL, SSFB_TX_STUCK, SSFB_BUS_STUCK,
                            SSFB_SUPPLY_LOW, SSFB_TX_WAIT} ssfb_tx_state_t;
  ssfb_tx_state_t tx_state;
  logic [31:0] tx_en_cnt;

  // Thermal and supply have priority: they keep the transmitter off longest
  always_ff @(posedge clock)
  begin
    if (!reset_n || flag_clear_all)
    begin
      tx_state <= SSFB_TX_ON;
      tx_en_cnt <= 32'h0;
      lin2_tx_enable <= 1'b1;
    end
    else if (lin2_thermal_event)
    begin
      tx_state <= SSFB_TX_THERMAL;
      tx_en_cnt <= 32'h0;
      lin2_tx_enable <= 1'b0;
    end
    else if (supply_uv_event)
    begin
      tx_state <= SSFB_SUPPLY_LOW;
      tx_en_cnt <= 32'h0;
      lin2_tx_enable <= 1'b0;
    end
    else if (bus_stuck_event)
    begin
      tx_state <= SSFB_BUS_STUCK;
      tx_en_cnt <= 32'h0;
      lin2_tx_enable <= 1'b0;
    end
    else if (tx_stuck_event)
    begin
      tx_state <= SSFB_TX_STUCK;
      tx_en_cnt <= 32'h0;
      lin2_tx_enable <= 1'b0;
    end
    else
    begin
      unique case (tx_state)
        SSFB_TX_ON:
          lin2_tx_enable <= 1'b1;
        SSFB_TX_THERMAL:
          if (!lin2_thermal_active)
            tx_state <= SSFB_TX_WAIT;
        SSFB_TX_STUCK:
          if (txd_high || lin2_wake_or_off)
            tx_state <= SSFB_TX_WAIT;
        SSFB_BUS_STUCK:
          if (!bus_dom || lin2_wake_or_off)
            tx_state <= SSFB_TX_WAIT;
        SSFB_SUPPLY_LOW:
          if (supply_above_uv)
            tx_state <= SSFB_TX_WAIT;
        SSFB_TX_WAIT:
        begin
          // Any low on the transmit input restarts the enable time
          if (!txd_high)
            tx_en_cnt <= 32'h0;
          else if (tx_en_cnt >= 32'(TX_EN_CYCLES - 1))
          begin
            tx_en_cnt <= 32'h0;
            tx_state <= SSFB_TX_ON;
            lin2_tx_enable <= 1'b1;
          end
          else
            tx_en_cnt <= tx_en_cnt + 32'h1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Second LIN fault code
  // ---------------------------------------------------------------
  logic [1:0] second_lin_fault_code;
  logic [1:0] next_fault_code;

  // Most severe new event wins; a new event beats a same-cycle clear
  always_comb
  begin
    next_fault_code = second_lin_fault_code;
    if (bus_stuck_event)
      next_fault_code = ssfb_pkg::FAULT_BUS_STUCK;
    else if (tx_stuck_event)
      next_fault_code = ssfb_pkg::FAULT_TX_STUCK;
    else if (lin2_thermal_event)
      next_fault_code = ssfb_pkg::FAULT_THERMAL;
    else if (clear_hit(acc_valid, acc_clear, acc_addr, ssfb_pkg::OFF_LIN2_FAULT_STATUS))
      next_fault_code = ssfb_pkg::FAULT_NONE;
  end

  // Restart leaves the code untouched
  always_ff @(posedge clock)
  begin
    if (!reset_n || flag_clear_all)
      second_lin_fault_code <= ssfb_pkg::FAULT_NONE;
    else
      second_lin_fault_code <= next_fault_code;
  end

  // ---------------------------------------------------------------
  // Wake flags
  // ---------------------------------------------------------------
  logic [6:0] wake_a;
  logic [6:0] wake_a_set;
  logic [1:0] wake_b;

  // Order: lin2, lin1, can, timer, input three..one
  assign wake_a_set = {second_lin_wake, first_lin_wake, can_bus_wake, timer_wake,
                       wake_input_event}
                      | (failsafe_exit ? failsafe_wake_source : 7'h00);

  // Set wins over the host clear
  always_ff @(posedge clock)
  begin
    if (!reset_n || flag_clear_all)
    begin
      wake_a <= 7'h00;
      wake_b <= 2'h0;
    end
    else
    begin
      if (clear_hit(acc_valid, acc_clear, acc_addr, ssfb_pkg::OFF_WAKE_SOURCE_FLAGS_A))
        wake_a <= wake_a_set;
      else
        wake_a <= wake_a | wake_a_set;
      if (clear_hit(acc_valid, acc_clear, acc_addr, ssfb_pkg::OFF_WAKE_SOURCE_FLAGS_B))
        wake_b <= gp_pin_wake;
      else
        wake_b <= wake_b | gp_pin_wake;
    end
  end

  // ---------------------------------------------------------------
  // Levels and straps
  // ---------------------------------------------------------------
  logic development_mode_indicator;
  logic interrupt_pullup_strap;
  logic strap_taken;
  logic [2:0] wk_level;
  logic [1:0] gp_level;

  // Straps caught once after reset release, from synchronised pins
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      strap_taken <= 1'b0;
      development_mode_indicator <= 1'b0;
      interrupt_pullup_strap <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1;
      development_mode_indicator <= test_lvl;
      interrupt_pullup_strap <= pullup_lvl;
    end
  end

  // Wake inputs: live, or held between samples in cyclic sense
  generate
    for (gi = 0; gi < NUM_WAKE_INPUTS; gi++)
    begin : g_wk_lvl
      always_ff @(posedge clock)
      begin
        if (!reset_n)
          wk_level[gi] <= 1'b0;
        else if (!wake_input_cyclic[gi] || wake_input_sample[gi])
          wk_level[gi] <= wk_lvl[gi];
      end
    end
  endgenerate

  // General pins follow the pin live while configured in normal or stop mode, else hold; no sampling path exists
  ssfb_pkg::ssfb_gp_cfg_t gp_cfg [2];
  assign gp_cfg[0] = ssfb_pkg::ssfb_gp_cfg_t'(gp_pin_cfg);
  assign gp_cfg[1] = ssfb_pkg::ssfb_gp_cfg_t'(gp_pin_cfg_b);
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_gp_lvl
      always_ff @(posedge clock)
      begin
        if (!reset_n)
          gp_level[gi] <= 1'b0;
        else if (normal_or_stop_mode && gp_cfg[gi] != ssfb_pkg::SSFB_GP_OFF)
          gp_level[gi] <= gp_lvl[gi];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // High-side switch flags
  // ---------------------------------------------------------------
  logic [NUM_HS-1:0] hs_overload;
  logic [NUM_HS-1:0] hs_open_load;

  // Low-supply glitches are latched like real faults; host filters them
  always_ff @(posedge clock)
  begin
    if (!reset_n || flag_clear_all || restart && 1'b0)
    begin
      hs_overload <= '0;
      hs_open_load <= '0;
    end
    else
    begin
      if (clear_hit(acc_valid, acc_clear, acc_addr, ssfb_pkg::OFF_HIGHSIDE_OVERLOAD_FLAGS))
        hs_overload <= hs_overload_event;
      else
        hs_overload <= hs_overload | hs_overload_event;
      if (clear_hit(acc_valid, acc_clear, acc_addr, ssfb_pkg::OFF_HIGHSIDE_OPENLOAD_FLAGS))
        hs_open_load <= hs_open_load_event;
      else
        hs_open_load <= hs_open_load | hs_open_load_event;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [7:0] next_rd_data;

  // Reserved positions are constant zero; unmapped addresses read zero
  always_comb
  begin
    next_rd_data = ssfb_pkg::STATUS_RESET;
    unique case (acc_addr)
      ssfb_pkg::OFF_LIN2_FAULT_STATUS:
        next_rd_data = {5'h00, second_lin_fault_code, 1'b0};
      ssfb_pkg::OFF_WAKE_SOURCE_FLAGS_A:
        next_rd_data = {wake_a[6:3], 1'b0, wake_a[2:0]};
      ssfb_pkg::OFF_WAKE_SOURCE_FLAGS_B:
        next_rd_data = {2'h0, wake_b, 4'h0};
      ssfb_pkg::OFF_WAKE_INPUT_LEVELS:
        next_rd_data = {development_mode_indicator, interrupt_pullup_strap, gp_level, 1'b0,
                        wk_level};
      ssfb_pkg::OFF_HIGHSIDE_OVERLOAD_FLAGS:
        next_rd_data = {4'h0, hs_overload};
      ssfb_pkg::OFF_HIGHSIDE_OPENLOAD_FLAGS:
        next_rd_data = {4'h0, hs_open_load};
      default:
        next_rd_data = ssfb_pkg::STATUS_RESET;
    endcase
  end

  // Data shows the value before any clear in the same access
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      rd_valid <= 1'b0;
      rd_data <= ssfb_pkg::STATUS_RESET;
    end
    else
    begin
      rd_valid <= acc_valid;
      if (acc_valid)
        rd_data <= next_rd_data;
    end
  end

endmodule

// >>> verilog/ssfb_pkg.sv
// Package of the status flag bank: register offsets, field positions,
// reset values and timing counts.
// Assumes a 100 MHz system clock feeding the bank.
package ssfb_pkg;

  // ---------------------------------------------------------------
  // Register offsets (7-bit serial port address)
  // ---------------------------------------------------------------
  localparam logic [6:0] OFF_LIN2_FAULT_STATUS = 7'h45;
  localparam logic [6:0] OFF_WAKE_SOURCE_FLAGS_A = 7'h46;
  localparam logic [6:0] OFF_WAKE_SOURCE_FLAGS_B = 7'h47;
  localparam logic [6:0] OFF_WAKE_INPUT_LEVELS = 7'h48;
  localparam logic [6:0] OFF_HIGHSIDE_OVERLOAD_FLAGS = 7'h54;
  localparam logic [6:0] OFF_HIGHSIDE_OPENLOAD_FLAGS = 7'h55;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FAULT_CODE_LSB = 1;
  localparam int WAKE_A_SECOND_LIN = 7;
  localparam int WAKE_A_FIRST_LIN = 6;
  localparam int WAKE_A_CAN = 5;
  localparam int WAKE_A_TIMER = 4;
  localparam int WAKE_A_INPUT_LSB = 0;
  localparam int WAKE_B_GP_LSB = 4;
  localparam int LVL_DEV_MODE = 7;
  localparam int LVL_PULLUP_STRAP = 6;
  localparam int LVL_GP_LSB = 4;
  localparam int LVL_WAKE_INPUT_LSB = 0;

  // ---------------------------------------------------------------
  // Reset values and fault codes
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_THERMAL = 2'h1;
  localparam logic [1:0] FAULT_TX_STUCK = 2'h2;
  localparam logic [1:0] FAULT_BUS_STUCK = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 100000000;
  localparam longint DOMINANT_TIMEOUT_MS = 20;
  localparam longint DOMINANT_TIMEOUT_CYCLES = DOMINANT_TIMEOUT_MS * CLK_HZ / 1000;
  localparam longint TX_ENABLE_TIME_NS = 10000;
  localparam longint TX_ENABLE_CYCLES = (TX_ENABLE_TIME_NS * CLK_HZ + 999999999) / 1000000000;

  // General-purpose pin configuration
  typedef enum logic [1:0] {SSFB_GP_OFF, SSFB_GP_WAKE, SSFB_GP_LOW_SW, SSFB_GP_HIGH_SW}
    ssfb_gp_cfg_t;

endpackage

// >>> tb/ssfb_host_model.sv
// Host side model: issues one register access at a time on the port.
// Assumes the bench calls access() and drives it from the falling edge.
`timescale 1ns/100ps
module ssfb_host_model (
  input wire logic clock,
  output logic acc_valid,
  output logic [6:0] acc_addr,
  output logic acc_clear
);
  // ---------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------
  // Address idles at a changing value so stale data cannot match
  initial
  begin
    acc_valid = 1'b0;
    acc_addr = 7'h7F;
    acc_clear = 1'b0;
  end

  // ---------------------------------------------------------------
  // Access
  // ---------------------------------------------------------------
  // One cycle request; flags are cleared only when asked for
  task automatic access(input logic [6:0] a, input logic c);
    @(negedge clock);
    acc_valid = 1'b1;
    acc_addr = a;
    acc_clear = c;
    @(negedge clock);
    acc_valid = 1'b0;
    acc_clear = 1'b0;
    acc_addr = ~a;
  endtask
endmodule

// >>> tb/ssfb_status_flag_bank_props.sv
// Checker of the flag bank: answer timing, reserved bits, flag latching.
// Assumes it is bound to the bank top and sees only its ports.
`timescale 1ns/100ps
module ssfb_props (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic acc_valid,
  input wire logic [6:0] acc_addr,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic lin2_txd_pin,
  input wire logic lin2_tx_enable,
  input wire logic timer_wake,
  input wire logic [3:0] hs_overload_event
);
  // ---------------------------------------------------------------
  // Sequences and properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Answer to a read of one address
  sequence s_rd(a);
    rd_valid && $past(acc_addr) == a;
  endsequence
  // Event, one quiet cycle, then a read of its register
  sequence s_timer;
    timer_wake ##1 !acc_valid ##1 acc_valid && acc_addr == 7'h46;
  endsequence
  sequence s_ovl;
    hs_overload_event[0] ##1 !acc_valid ##1 acc_valid && acc_addr == 7'h54;
  endsequence
  a_read_answer: assert property (acc_valid |=> rd_valid) else $error("no answer");
  a_no_stray: assert property (!acc_valid |=> !rd_valid) else $error("stray answer");
  a_fault_rsvd: assert property (s_rd(7'h45) |-> rd_data[7:3] == 5'h0 && !rd_data[0])
    else $error("fault reserved set");
  a_wake_a_rsvd: assert property (s_rd(7'h46) |-> !rd_data[3]) else $error("wake bit3");
  a_wake_b_rsvd: assert property (s_rd(7'h47) |-> {rd_data[7:6], rd_data[3:0]} == 6'h0)
    else $error("wake b reserved set");
  a_level_rsvd: assert property (s_rd(7'h48) |-> !rd_data[3]) else $error("level bit3");
  a_hs_rsvd: assert property (s_rd(7'h54) or s_rd(7'h55) |-> rd_data[7:4] == 4'h0)
    else $error("switch reserved set");
  a_timer_flag: assert property (s_timer |=> rd_data[4]) else $error("timer lost");
  a_ovl_flag: assert property (s_ovl |=> rd_data[0]) else $error("overload lost");
  // Soft reset re-enables at once, with no hold time to honour
  a_tx_hold_off: assert property ($rose(lin2_tx_enable) && !$past(soft_reset) |->
    $past(lin2_txd_pin, 3) && $past(lin2_txd_pin, 9)) else $error("early enable");
endmodule

bind ssfb_status_flag_bank ssfb_props chk_u (.clock, .reset_n, .soft_reset, .acc_valid, .acc_addr,
  .rd_valid, .rd_data, .lin2_txd_pin, .lin2_tx_enable, .timer_wake, .hs_overload_event);

// >>> tb/tb_ssfb_status_flag_bank.sv
// Bench of the flag bank: events, timeouts and levels, read back by host.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/100ps
module tb_ssfb_status_flag_bank;
  localparam int DOM = 50;
  localparam int TXE = 8;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [24:0] ev = '0;
  logic soft_reset, restart, acc_valid, acc_clear, rd_valid, lin2_tx_enable;
  logic lin2_thermal_event, supply_uv_event, failsafe_exit, timer_wake;
  logic second_lin_wake, first_lin_wake, can_bus_wake;
  logic [2:0] wake_input_event, wake_input_sample;
  logic [1:0] gp_pin_wake;
  logic [3:0] hs_overload_event, hs_open_load_event;
  logic [6:0] acc_addr;
  logic [7:0] rd_data, b;
  logic lin2_txd_pin = 1'b1;
  logic lin2_bus_dominant_pin = 1'b0;
  logic lin2_wake_or_off = 1'b0;
  logic lin2_thermal_active = 1'b0;
  logic supply_above_uv = 1'b1;
  logic [2:0] wake_input_pin = 3'h0;
  logic [2:0] wake_input_cyclic = 3'h0;
  logic [1:0] gp_pin = 2'h0;
  logic [1:0] gp_pin_cfg = 2'h1;
  logic [1:0] gp_pin_cfg_b = 2'h1;
  logic [6:0] fs_src = 7'h0;
  logic [7:0] expq[$];
  logic [6:0] offs[7] = '{7'h45, 7'h46, 7'h47, 7'h48, 7'h54, 7'h55, 7'h50};
  logic [31:0] r = 32'hB226;
  int fail_count = 0;
  int n_compared = 0;

  // Pulse inputs share one vector so a task can raise any mix
  assign {soft_reset, restart, wake_input_sample, supply_uv_event, lin2_thermal_event,
    failsafe_exit, second_lin_wake, first_lin_wake, can_bus_wake, timer_wake,
    wake_input_event, gp_pin_wake, hs_overload_event, hs_open_load_event} = ev;

  // ---------------------------------------------------------------
  // Design and host
  // ---------------------------------------------------------------
  ssfb_status_flag_bank #(.DOM_TIMEOUT_CYCLES(DOM), .TX_EN_CYCLES(TXE)) dut_u (.clock,
    .reset_n, .soft_reset, .restart, .acc_valid, .acc_addr, .acc_clear, .rd_valid,
    .rd_data, .lin2_txd_pin, .lin2_bus_dominant_pin, .lin2_wake_or_off,
    .lin2_thermal_event, .lin2_thermal_active, .supply_uv_event,
    .supply_above_uv, .lin2_tx_enable, .second_lin_wake, .first_lin_wake,
    .can_bus_wake, .timer_wake, .wake_input_event, .gp_pin_wake, .failsafe_exit,
    .failsafe_wake_source(fs_src), .test_select_pin(1'b1), .interrupt_pullup_pin(1'b0),
    .wake_input_pin, .wake_input_cyclic, .wake_input_sample, .gp_pin, .gp_pin_cfg,
    .gp_pin_cfg_b, .normal_or_stop_mode(1'b1), .hs_overload_event, .hs_open_load_event);
  ssfb_host_model host_u (.clock, .acc_valid, .acc_addr, .acc_clear);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Note the answer first, then let the host make the access
  task automatic rd(input logic [6:0] a, input logic c, input logic [7:0] e);
    expq.push_back(e);
    host_u.access(a, c);
  endtask
  task automatic pulse(input logic [24:0] v);
    @(negedge clock);
    ev = v;
    @(negedge clock);
    ev = '0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic tx(input logic e);
    chk({7'h0, lin2_tx_enable}, {7'h0, e});
  endtask
  task automatic results;
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watcher, watchdog
  // ---------------------------------------------------------------
  initial
    forever #5 clock = ~clock;
  // Answers stand one cycle; the falling edge sees them settled
  always @(negedge clock)
    if (rd_valid === 1'b1)
      chk(rd_data, (expq.size() > 0) ? expq.pop_front() : ~rd_data);
  // Whole run is some five hundred cycles
  initial
  begin
    cyc(20000);
    fail_count++;
    $display("unexpected at %0t: run hung", $time);
    results();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    cyc(3);
    reset_n = 1'b1;
    foreach (offs[i]) rd(offs[i], 1'b1, (i == 3) ? 8'h80 : 8'h00);
    $display("test reset done");
    for (int k = 0; k < 8; k++)
      if (k != 3)
      begin
        b = 8'h1 << k;
        pulse(25'h1 << ((k < 3) ? 10 + k : 9 + k));
        rd(7'h46, 1'b0, b);
        rd(7'h46, 1'b1, b);
        rd(7'h46, 1'b0, 8'h00);
      end
    r = lfsr(r);
    fs_src = r[6:0];
    pulse(25'h1 << 17);
    rd(7'h46, 1'b1, {r[6:3], 1'b0, r[2:0]});
    pulse(25'h3 << 8);
    rd(7'h47, 1'b1, 8'h30);
    rd(7'h47, 1'b0, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      r = lfsr(r);
      pulse({17'h0, r[7:0] | 8'h11});
      rd(7'h54, 1'b1, {4'h0, r[7:4] | 4'h1});
      rd(7'h55, 1'b1, {4'h0, r[3:0] | 4'h1});
      rd(7'h54, 1'b0, 8'h00);
    end
    $display("test flags done");
    for (int i = 1; i < 4; i++)
    begin
      r = lfsr(r);
      wake_input_pin = r[2:0];
      gp_pin = r[4:3];
      gp_pin_cfg = 2'(i);
      gp_pin_cfg_b = 2'(4 - i);
      cyc(5);
      rd(7'h48, 1'b1, {2'h2, r[4:3], 1'b0, r[2:0]});
    end
    // Sampled inputs keep the old level until the next sample
    wake_input_cyclic = 3'h7;
    pulse(25'h7 << 20);
    // First general pin switched off: its level bit must hold the old value
    b = {5'h0, wake_input_pin};
    gp_pin_cfg = 2'h0;
    wake_input_pin = ~wake_input_pin;
    gp_pin = ~gp_pin;
    cyc(5);
    rd(7'h48, 1'b0, {2'h2, gp_pin[1], ~gp_pin[0], 1'b0, b[2:0]});
    pulse(25'h7 << 20);
    cyc(3);
    rd(7'h48, 1'b0, {2'h2, gp_pin[1], ~gp_pin[0], 1'b0, wake_input_pin});
    wake_input_cyclic = 3'h0;
    $display("test levels done");
    lin2_bus_dominant_pin = 1'b1;
    cyc(DOM - 10);
    rd(7'h45, 1'b0, 8'h00);
    cyc(20);
    rd(7'h45, 1'b0, 8'h06);
    tx(1'b0);
    pulse(25'h1 << 23);
    rd(7'h45, 1'b0, 8'h06);
    lin2_bus_dominant_pin = 1'b0;
    cyc(3);
    tx(1'b0);
    cyc(20);
    tx(1'b1);
    rd(7'h45, 1'b1, 8'h06);
    rd(7'h45, 1'b0, 8'h00);
    lin2_bus_dominant_pin = 1'b1;
    cyc(DOM + 10);
    lin2_wake_or_off = 1'b1;
    cyc(20);
    tx(1'b1);
    lin2_bus_dominant_pin = 1'b0;
    cyc(3);
    lin2_wake_or_off = 1'b0;
    rd(7'h45, 1'b1, 8'h06);
    lin2_txd_pin = 1'b0;
    cyc(DOM + 10);
    rd(7'h45, 1'b0, 8'h04);
    lin2_txd_pin = 1'b1;
    cyc(20);
    tx(1'b1);
    rd(7'h45, 1'b1, 8'h04);
    // Overtemperature and low supply keep the transmitter off while they last
    lin2_thermal_active = 1'b1;
    pulse(25'h1 << 18);
    cyc(20);
    tx(1'b0);
    rd(7'h45, 1'b1, 8'h02);
    lin2_thermal_active = 1'b0;
    cyc(20);
    tx(1'b1);
    supply_above_uv = 1'b0;
    pulse(25'h1 << 19);
    cyc(20);
    tx(1'b0);
    rd(7'h45, 1'b0, 8'h00);
    supply_above_uv = 1'b1;
    cyc(20);
    tx(1'b1);
    $display("test faults done");
    pulse(25'h1FFFF);
    rd(7'h46, 1'b0, 8'hF7);
    pulse(25'h1 << 24);
    foreach (offs[i]) if (i != 3) rd(offs[i], 1'b0, 8'h00);
    $display("test soft reset done");
    cyc(5);
    results();
  end
endmodule
